/* File: rtl/reconnection_element_pkg.sv */
// constants, offsets and types of the reconnection release block
package reconnection_element_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_FREQ_KHZ = 200000;
  localparam int unsigned TICK_PERIOD_MS = 1000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_MS * CLK_FREQ_KHZ;
  localparam int unsigned BLOCK_TIME_MIN = 10;
  localparam int unsigned QUAL_TIME_MIN = 5;
  localparam logic [15:0] BLOCK_TIME_DEF = 16'(BLOCK_TIME_MIN * 60);
  localparam logic [15:0] QUAL_TIME_DEF = 16'(QUAL_TIME_MIN * 60);
  // ==========================================================
  // band defaults: frequency in mHz, voltage in units of 10 V
  localparam logic [15:0] FREQ_LO_DEF = 16'hB98C;
  localparam logic [15:0] FREQ_HI_DEF = 16'hC92C;
  localparam logic [15:0] VOLT_LO_DEF = 16'h2486;
  localparam logic [15:0] VOLT_HI_DEF = 16'h319C;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TRIG_MASK = 8'h04;
  localparam logic [7:0] OFS_BLOCK_TIME = 8'h08;
  localparam logic [7:0] OFS_QUAL_TIME = 8'h0C;
  localparam logic [7:0] OFS_FREQ_LO = 8'h10;
  localparam logic [7:0] OFS_FREQ_HI = 8'h14;
  localparam logic [7:0] OFS_VOLT_LO = 8'h18;
  localparam logic [7:0] OFS_VOLT_HI = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_INT_STATUS = 8'h24;
  localparam logic [7:0] OFS_INT_MASK = 8'h28;
  localparam logic [7:0] OFS_LAST = 8'h28;
  // ==========================================================
  // fields
  localparam int CTRL_EXT_EN_BIT = 0;
  localparam int CTRL_COND_LSB = 1;
  localparam int CTRL_AVG_BIT = 3;
  localparam int CTRL_SWTRIG_BIT = 4;
  localparam logic [7:0] TRIG_MASK_DEF = 8'h3F;
  localparam int NUM_DECOUPLE = 6;
  localparam int INT_DECOUPLE = 0;
  localparam int INT_RELEASE = 1;
  localparam int INT_RESTART = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    COND_INTERNAL = 2'h0,
    COND_EXTERNAL = 2'h1,
    COND_BOTH = 2'h2
  } cond_type;
  typedef enum logic [2:0] {
    ST_BLOCK = 3'h1,
    ST_WAIT = 3'h2,
    ST_RELEASED = 3'h4
  } state_type;
endpackage : reconnection_element_pkg

/* File: rtl/band_check.sv */
// acceptance window check of three line voltages and frequency
`timescale 1ns/100ps
module band_check
  import reconnection_element_pkg::*;
(
  input wire logic [15:0] volt_ab,
  input wire logic [15:0] volt_bc,
  input wire logic [15:0] volt_ca,
  input wire logic [15:0] freq,
  input wire logic [15:0] volt_lo,
  input wire logic [15:0] volt_hi,
  input wire logic [15:0] freq_lo,
  input wire logic [15:0] freq_hi,
  output logic in_band
);
  // ==========================================================
  // per-value window test
  function automatic logic inside_win(input logic [15:0] v, input logic [15:0] lo,
                                      input logic [15:0] hi);
    inside_win = (v >= lo) && (v <= hi);
  endfunction : inside_win

  logic [15:0] volt_arr [3];
  logic [2:0] volt_ok;

  assign volt_arr[0] = volt_ab;
  assign volt_arr[1] = volt_bc;
  assign volt_arr[2] = volt_ca;

  // every line-to-line voltage must sit in its window
  for (genvar i = 0; i < 3; i++) begin : g_volt
    assign volt_ok[i] = inside_win(volt_arr[i], volt_lo, volt_hi);
  end

  // combined acceptance
  assign in_band = (&volt_ok) && inside_win(freq, freq_lo, freq_hi);
endmodule : band_check

/* File: rtl/grid_reconnection_release.sv */
// reconnection release logic with axi4-lite register slave
// Overview of operation
// - Starts come from six decoupling elements, digital input, logic or supervisory command.
// - After decoupling the release is held blocked for a settable time, ten minutes by default.
// - Internal release needs voltage and frequency in band without a break for a settable time.
// - Voltages judged are the mains-side line-to-line values plus mains frequency.
// - A coupling-point breaker trip needs manual reconnection and gets no blocking logic here.
// - The release condition selects internal, external or both together.
// - Internal mode decides release from the block's own mains-side voltage measurement.
// - With the external function enabled, external and both modes use the remote release input; internal mode ignores it.
// - Both mode releases only while internal and external release hold together.
// - Assigned triggers are OR-ed and any one starts the blocking timer.
// - No release can happen before the blocking timer has fully run out.
// - Leaving the band before the blocking time ends restarts that timer from zero.
// - Settable lower and upper limits for voltage and frequency form the window.
// - Default window is 47.5 to 51.5 Hz with five minutes of qualification.
// - In averaged mode internal release uses one-minute average voltages.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module grid_reconnection_release
  import reconnection_element_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [NUM_DECOUPLE-1:0] decouple_trig,
  input wire logic digital_trig,
  input wire logic logic_trig,
  input wire logic external_release_input,
  input wire logic [15:0] volt_ab,
  input wire logic [15:0] volt_bc,
  input wire logic [15:0] volt_ca,
  input wire logic [15:0] volt_ab_avg,
  input wire logic [15:0] volt_bc_avg,
  input wire logic [15:0] volt_ca_avg,
  input wire logic [15:0] mains_freq,
  output logic reconnect_release,
  output logic release_blocked,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ==========================================================
  // declarations
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_got_ff, w_got_ff, ar_got_ff;
  logic [7:0] awaddr_ff, araddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic ext_en_ff, avg_ff, sw_trig_ff;
  logic [1:0] cond_ff;
  logic [7:0] trig_mask_ff;
  logic [15:0] block_time_ff, qual_time_ff;
  logic [15:0] freq_lo_ff, freq_hi_ff, volt_lo_ff, volt_hi_ff;
  logic [2:0] ists_ff, imask_ff;
  logic irq_ff, release_ff, blocked_ff;
  state_type state_ff;
  logic [15:0] block_cnt_ff, qual_cnt_ff;
  logic [31:0] tick_cnt_ff;
  logic tick_ff;
  logic wr_fire, trig_any, in_band, block_done, qual_done, int_ok, ext_ok, rel_cond;
  logic [15:0] sel_ab, sel_bc, sel_ca;
  logic [31:0] wr_word;
  logic [2:0] ists_set;

  // ==========================================================
  // address decode and strobe merge
  function automatic logic reg_hit(input logic [7:0] addr);
    reg_hit = (addr[1:0] == 2'h0) && (addr <= OFS_LAST);
  endfunction : reg_hit

  function automatic logic [31:0] merge_strb(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] strb);
    merge_strb = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge_strb[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
  endfunction : merge_strb

  function automatic logic [31:0] reg_value(input logic [7:0] addr);
    case (addr)
      OFS_CTRL: reg_value = {27'h0, 1'b0, avg_ff, cond_ff, ext_en_ff};
      OFS_TRIG_MASK: reg_value = {24'h0, trig_mask_ff};
      OFS_BLOCK_TIME: reg_value = {16'h0, block_time_ff};
      OFS_QUAL_TIME: reg_value = {16'h0, qual_time_ff};
      OFS_FREQ_LO: reg_value = {16'h0, freq_lo_ff};
      OFS_FREQ_HI: reg_value = {16'h0, freq_hi_ff};
      OFS_VOLT_LO: reg_value = {16'h0, volt_lo_ff};
      OFS_VOLT_HI: reg_value = {16'h0, volt_hi_ff};
      OFS_STATUS: reg_value = {26'h0, trig_any, external_release_input, in_band, int_ok,
                               blocked_ff, release_ff};
      OFS_INT_STATUS: reg_value = {29'h0, ists_ff};
      OFS_INT_MASK: reg_value = {29'h0, imask_ff};
      default: reg_value = 32'h0000_0000;
    endcase
  endfunction : reg_value

  assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
  always_comb wr_word = merge_strb(reg_value(awaddr_ff), wdata_ff, wstrb_ff); // sees regs in fn

  // ==========================================================
  // axi write channels
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awaddr_ff <= s_axi_awaddr;
        aw_got_ff <= 1'b1;
        awready_ff <= 1'b0;
      end else if (!aw_got_ff) begin
        awready_ff <= 1'b1;
      end
      if (s_axi_wvalid && wready_ff) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        w_got_ff <= 1'b1;
        wready_ff <= 1'b0;
      end else if (!w_got_ff) begin
        wready_ff <= 1'b1;
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= reg_hit(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // axi read channels
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      arready_ff <= 1'b0;
      ar_got_ff <= 1'b0;
      araddr_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && arready_ff) begin
        araddr_ff <= s_axi_araddr;
        ar_got_ff <= 1'b1;
        arready_ff <= 1'b0;
      end else if (!ar_got_ff) begin
        arready_ff <= 1'b1;
      end
      if (ar_got_ff && !rvalid_ff) begin
        ar_got_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= reg_value(araddr_ff);
        rresp_ff <= reg_hit(araddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ext_en_ff <= 1'b0;
      cond_ff <= COND_INTERNAL;
      avg_ff <= 1'b0;
      sw_trig_ff <= 1'b0;
      trig_mask_ff <= TRIG_MASK_DEF;
      block_time_ff <= BLOCK_TIME_DEF;
      qual_time_ff <= QUAL_TIME_DEF;
      freq_lo_ff <= FREQ_LO_DEF;
      freq_hi_ff <= FREQ_HI_DEF;
      volt_lo_ff <= VOLT_LO_DEF;
      volt_hi_ff <= VOLT_HI_DEF;
      imask_ff <= 3'h0;
    end else begin
      sw_trig_ff <= 1'b0;
      if (wr_fire) begin
        case (awaddr_ff)
          OFS_CTRL: begin
            ext_en_ff <= wr_word[CTRL_EXT_EN_BIT];
            cond_ff <= wr_word[CTRL_COND_LSB +: 2];
            avg_ff <= wr_word[CTRL_AVG_BIT];
            sw_trig_ff <= wr_word[CTRL_SWTRIG_BIT];
          end
          OFS_TRIG_MASK: trig_mask_ff <= wr_word[7:0];
          OFS_BLOCK_TIME: block_time_ff <= wr_word[15:0];
          OFS_QUAL_TIME: qual_time_ff <= wr_word[15:0];
          OFS_FREQ_LO: freq_lo_ff <= wr_word[15:0];
          OFS_FREQ_HI: freq_hi_ff <= wr_word[15:0];
          OFS_VOLT_LO: volt_lo_ff <= wr_word[15:0];
          OFS_VOLT_HI: volt_hi_ff <= wr_word[15:0];
          OFS_INT_MASK: imask_ff <= wr_word[2:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // sticky interrupt flags, set beats write-one clear
  assign ists_set[INT_DECOUPLE] = trig_any;
  assign ists_set[INT_RELEASE] = (state_ff == ST_WAIT) && rel_cond && !trig_any;
  assign ists_set[INT_RESTART] = (state_ff == ST_BLOCK) && !in_band && (block_cnt_ff != 16'h0);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ists_ff <= 3'h0;
      irq_ff <= 1'b0;
    end else begin
      if (wr_fire && (awaddr_ff == OFS_INT_STATUS)) begin
        ists_ff <= (ists_ff & ~wr_word[2:0]) | ists_set;
      end else begin
        ists_ff <= ists_ff | ists_set;
      end
      irq_ff <= |(ists_ff & imask_ff);
    end
  end

  // ==========================================================
  // one-second tick
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff >= 32'(TICK_CYCLES_P - 1)) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
      tick_ff <= 1'b0;
    end
  end

  // ==========================================================
  // trigger combine and voltage source
  assign trig_any = |(decouple_trig & trig_mask_ff[NUM_DECOUPLE-1:0])
                    || (digital_trig && trig_mask_ff[NUM_DECOUPLE])
                    || (logic_trig && trig_mask_ff[NUM_DECOUPLE+1])
                    || sw_trig_ff;
  // a coupling-point breaker trip is left to manual reconnection
  assign sel_ab = avg_ff ? volt_ab_avg : volt_ab;
  assign sel_bc = avg_ff ? volt_bc_avg : volt_bc;
  assign sel_ca = avg_ff ? volt_ca_avg : volt_ca;

  band_check u_band (
    .volt_ab(sel_ab),
    .volt_bc(sel_bc),
    .volt_ca(sel_ca),
    .freq(mains_freq),
    .volt_lo(volt_lo_ff),
    .volt_hi(volt_hi_ff),
    .freq_lo(freq_lo_ff),
    .freq_hi(freq_hi_ff),
    .in_band(in_band)
  );

  // ==========================================================
  // blocking and qualification timers
  assign block_done = block_cnt_ff >= block_time_ff;
  assign qual_done = qual_cnt_ff >= qual_time_ff;
  assign int_ok = qual_done && in_band;
  assign ext_ok = ext_en_ff && external_release_input;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      block_cnt_ff <= 16'h0000;
    end else if (trig_any || ((state_ff == ST_BLOCK) && !in_band)) begin
      block_cnt_ff <= 16'h0000;
    end else if ((state_ff == ST_BLOCK) && tick_ff && !block_done) begin
      block_cnt_ff <= block_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      qual_cnt_ff <= 16'h0000;
    end else if (trig_any || !in_band) begin
      qual_cnt_ff <= 16'h0000;
    end else if (tick_ff && !qual_done) begin
      qual_cnt_ff <= qual_cnt_ff + 16'h0001;
    end
  end

  // ==========================================================
  // release condition select
  always_comb begin
    case (cond_ff)
      COND_INTERNAL: rel_cond = int_ok;
      COND_EXTERNAL: rel_cond = ext_ok;
      COND_BOTH: rel_cond = int_ok && ext_ok;
      default: rel_cond = 1'b0;
    endcase
  end

  // ==========================================================
  // release state machine
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_BLOCK;
      release_ff <= 1'b0;
      blocked_ff <= 1'b1;
    end else if (trig_any) begin
      state_ff <= ST_BLOCK;
      release_ff <= 1'b0;
      blocked_ff <= 1'b1;
    end else begin
      case (state_ff)
        ST_BLOCK: begin
          if (block_done) begin
            state_ff <= ST_WAIT;
            blocked_ff <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (rel_cond) begin
            state_ff <= ST_RELEASED;
            release_ff <= 1'b1;
          end
        end
        ST_RELEASED: begin
          if (!rel_cond) begin
            state_ff <= ST_WAIT;
            release_ff <= 1'b0;
          end
        end
        default: begin
          state_ff <= ST_BLOCK;
          release_ff <= 1'b0;
          blocked_ff <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // outputs
  assign reconnect_release = release_ff;
  assign release_blocked = blocked_ff;
  assign irq = irq_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ==========================================================
  // checks
  a_trig_drops_release: assert property (@(posedge mclk) disable iff (!rstn)
    trig_any |=> (!release_ff && (state_ff == ST_BLOCK) && (block_cnt_ff == 16'h0)))
    else $error("trigger did not drop release and restart blocking");
  a_trig_sets_flag: assert property (@(posedge mclk) disable iff (!rstn)
    trig_any |=> ists_ff[INT_DECOUPLE])
    else $error("trigger did not set decoupling flag");
  a_band_restarts: assert property (@(posedge mclk) disable iff (!rstn)
    ((state_ff == ST_BLOCK) && !in_band) |=> (block_cnt_ff == 16'h0))
    else $error("blocking timer not restarted on band loss");
  a_release_after_block: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(release_ff) |-> ($past(block_cnt_ff) >= $past(block_time_ff)))
    else $error("release before blocking time elapsed");
  a_internal_qualified: assert property (@(posedge mclk) disable iff (!rstn)
    ($rose(release_ff) && ($past(cond_ff) == COND_INTERNAL))
      |-> ($past(qual_cnt_ff) >= $past(qual_time_ff)))
    else $error("internal release without qualification time");
  a_both_needs_and: assert property (@(posedge mclk) disable iff (!rstn)
    ((cond_ff == COND_BOTH) && !(int_ok && ext_ok)) |=> !release_ff)
    else $error("both mode released without both conditions");
  a_ext_needs_enable: assert property (@(posedge mclk) disable iff (!rstn)
    ((cond_ff == COND_EXTERNAL) && !ext_en_ff) |=> !release_ff)
    else $error("external release without function enable");
  a_band_freq_low: assert property (@(posedge mclk) disable iff (!rstn)
    ((mains_freq < freq_lo_ff) || (mains_freq > freq_hi_ff)) |-> (!in_band && !int_ok))
    else $error("frequency outside limits accepted");
  a_avg_source: assert property (@(posedge mclk) disable iff (!rstn)
    avg_ff |-> ((sel_ab == volt_ab_avg) && (sel_ca == volt_ca_avg)))
    else $error("averaged mode not using average voltages");
  a_block_tick_step: assert property (@(posedge mclk) disable iff (!rstn)
    (!tick_ff && !trig_any && (state_ff == ST_BLOCK) && in_band)
      |=> (block_cnt_ff == $past(block_cnt_ff)))
    else $error("blocking timer moved without a tick");
endmodule : grid_reconnection_release

/* File: bench/decouple_model.sv */
// partner model: decoupling sources, remote release and mains values
`timescale 1ns/100ps
module decouple_model
  import reconnection_element_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] trig_req,
  input wire logic ext_req,
  input wire logic band_ok,
  input wire logic avg_only,
  input wire logic [15:0] rnd,
  output logic [5:0] decouple_trig,
  output logic digital_trig,
  output logic logic_trig,
  output logic external_release_input,
  output logic [15:0] volt,
  output logic [15:0] volt_avg,
  output logic [15:0] mains_freq
);
  logic [15:0] v_ok;
  // ====================
  // trigger sources and remote release, changed after each edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {logic_trig, digital_trig, decouple_trig} <= 8'h00;
      external_release_input <= 1'b0;
    end else begin
      {logic_trig, digital_trig, decouple_trig} <= trig_req;
      external_release_input <= ext_req;
    end
  end
  // in-band values wander randomly, out-of-band values sit just past a limit
  assign v_ok = VOLT_LO_DEF + (rnd % 16'h0D17);
  always_comb begin
    volt = (band_ok && !avg_only) ? v_ok : VOLT_HI_DEF + 16'h0001;
    volt_avg = band_ok ? v_ok : VOLT_HI_DEF + 16'h0001;
    mains_freq = band_ok ? FREQ_LO_DEF + (rnd % 16'h0FA1) : FREQ_LO_DEF - 16'h0001;
  end
endmodule : decouple_model

/* File: bench/tb.sv */
// self-checking bench of the reconnection release block
`timescale 1ns/100ps
module tb
  import reconnection_element_pkg::*;
;
  // ====================
  // stimulus, expectations and the block
  logic mclk = 0, rstn = 0, ext_req = 0, band_ok = 1, avg_only = 0;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic awr, wr_rdy, bvalid, arr, rvalid, rel, blk, irq, dig, lgc, ext;
  logic [7:0] trig_req = 0, awaddr = 0, araddr = 0, row;
  logic [31:0] wdata = 0, rdata, lfsr = 32'hB62F7302;
  logic [1:0] bresp, rresp;
  logic [15:0] volt, vavg, freq, rnd = 0;
  logic [5:0] dtrig;
  logic [33:0] expq[$];
  logic [1:0] bq[$];
  logic [7:0] modes[13] = '{8'h05, 8'h15, 8'h08, 8'h06, 8'h87, 8'h39, 8'h34, 8'h5D, 8'h2C,
                            8'h5D, 8'h7C, 8'h54, 8'h58};
  int fail_count = 0, cmp_count = 0, cyc = 0, n;

  decouple_model decouple_model_inst (
    .mclk(mclk), .rstn(rstn), .trig_req(trig_req), .ext_req(ext_req), .band_ok(band_ok),
    .avg_only(avg_only), .rnd(rnd), .decouple_trig(dtrig), .digital_trig(dig),
    .logic_trig(lgc), .external_release_input(ext), .volt(volt), .volt_avg(vavg),
    .mains_freq(freq)
  );
  grid_reconnection_release #(.TICK_CYCLES_P(10)) grid_reconnection_release_inst (
    .mclk(mclk), .rstn(rstn), .decouple_trig(dtrig), .digital_trig(dig), .logic_trig(lgc),
    .external_release_input(ext), .volt_ab(volt), .volt_bc(volt), .volt_ca(volt),
    .volt_ab_avg(vavg), .volt_bc_avg(vavg), .volt_ca_avg(vavg), .mains_freq(freq),
    .reconnect_release(rel), .release_blocked(blk), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // ====================
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    lfsr_next = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr_next
  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic results;
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    bq.push_back(a > OFS_LAST ? RESP_SLVERR : RESP_OKAY);
    do begin
      @(posedge mclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge mclk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    expq.push_back(e);
    do begin
      @(posedge mclk);
      if (arv && arr) arv <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd
  task automatic wait_rel;
    n = 0;
    while (rel !== 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
    end
  endtask : wait_rel
  task automatic trig(input int i);
    @(posedge mclk);
    trig_req <= 8'h01 << i;
    @(posedge mclk);
    trig_req <= 8'h00;
    repeat (3) @(posedge mclk);
  endtask : trig

  // clock, random source and run-length guard
  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    lfsr <= lfsr_next(lfsr);
    rnd <= lfsr[15:0];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  // bus answers taken off the notes in order
  always @(posedge mclk) begin
    if (rvalid && rready) check("rdata", {rresp, rdata}, expq.pop_front());
    if (bvalid && bready) check("bresp", 34'(bresp), 34'(bq.pop_front()));
  end

  // main sequence
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    check("blocked", 34'({rel, blk}), 34'h1);
    rd(OFS_TRIG_MASK, {RESP_OKAY, 24'h0, TRIG_MASK_DEF});
    rd(OFS_BLOCK_TIME, {RESP_OKAY, 16'h0, BLOCK_TIME_DEF});
    rd(OFS_QUAL_TIME, {RESP_OKAY, 16'h0, QUAL_TIME_DEF});
    rd(OFS_FREQ_LO, {RESP_OKAY, 16'h0, FREQ_LO_DEF});
    rd(OFS_FREQ_HI, {RESP_OKAY, 16'h0, FREQ_HI_DEF});
    rd(8'h2C, {RESP_SLVERR, 32'h0});
    wr(8'h30, 32'h1);
    wr(OFS_BLOCK_TIME, 32'h8);
    wr(OFS_QUAL_TIME, 32'h2);
    wr(OFS_INT_MASK, 32'h7);
    wr(OFS_TRIG_MASK, 32'hFF);
    wait_rel();
    check("first release", 34'(rel), 34'h1);
    // every trigger input drops release and reblocks for the full time
    for (int i = 0; i < 8; i++) begin
      trig(i);
      check("trigger", 34'({rel, blk}), 34'h1);
      wait_rel();
      check("block time", 34'(n >= 60 && n < 400), 34'h1);
    end
    rd(OFS_INT_STATUS, {RESP_OKAY, 32'h3});
    check("irq on", 34'(irq), 34'h1);
    wr(OFS_INT_MASK, 32'h0);
    repeat (3) @(posedge mclk);
    check("irq masked", 34'(irq), 34'h0);
    wr(OFS_INT_STATUS, 32'h7);
    rd(OFS_INT_STATUS, {RESP_OKAY, 32'h0});
    // band loss in mid-block restarts the block time
    trig(0);
    repeat (40) @(posedge mclk);
    band_ok <= 1'b0;
    repeat (50) @(posedge mclk);
    band_ok <= 1'b1;
    wait_rel();
    check("restart", 34'(n >= 70 && n < 400), 34'h1);
    rd(OFS_INT_STATUS, {RESP_OKAY, 32'h7});
    // release condition selections against measurement and remote release
    for (int i = 0; i < 13; i++) begin
      row = modes[i];
      wr(OFS_CTRL, 32'(row[7:4]));
      ext_req <= row[3];
      band_ok <= row[2];
      avg_only <= row[1];
      repeat (60) @(posedge mclk);
      check("mode", 34'(rel), 34'(row[0]));
    end
    // software trigger reblocks; status shows blocked and the remote input
    wr(OFS_CTRL, 32'h10);
    repeat (2) @(posedge mclk);
    check("sw trigger", 34'({rel, blk}), 34'h1);
    rd(OFS_STATUS, {RESP_OKAY, 32'h12});
    results();
  end
endmodule : tb
